// >>> include/arith_exc_defines.svh
// Offsets, field positions, reset values of the arithmetic exception register group
`ifndef ARITH_EXC_DEFINES_SVH
`define ARITH_EXC_DEFINES_SVH

// ----------------------------------------------------------------
// Special register numbers
// ----------------------------------------------------------------
`define AEX_ADDR_BP_ALIAS 8'h85
`define AEX_ADDR_FC_ALIAS 8'h86
`define AEX_ADDR_CR_ALIAS 8'h87
`define AEX_ADDR_FENV 8'hA0
`define AEX_ADDR_IENV 8'hA1
`define AEX_ADDR_FSTAT 8'hA2
`define AEX_ADDR_OPCODE 8'hA4

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define AEX_BP_W 2
`define AEX_FC_W 5
`define AEX_CR_W 8
`define AEX_FENV_W 9
`define AEX_FENV_FAST_BIT 8
`define AEX_FENV_RND_MSB 7
`define AEX_FENV_RND_LSB 6
`define AEX_FENV_MASK_MSB 5
`define AEX_IENV_W 2
`define AEX_IENV_DIV_BIT 1
`define AEX_IENV_MUL_BIT 0
`define AEX_COND_W 6
`define AEX_FSTAT_TRAP_MSB 13
`define AEX_FSTAT_TRAP_LSB 8
`define AEX_FSTAT_STICKY_MSB 5
`define AEX_OPCODE_W 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AEX_RST_BP 2'h0
`define AEX_RST_FC 5'h00
`define AEX_RST_CR 8'h00
`define AEX_RST_FENV 9'h000
`define AEX_RST_IENV 2'h0
`define AEX_RST_COND 6'h00
`define AEX_RST_OPCODE 8'h00
`define AEX_RST_RDATA 32'h0000_0000

`endif

// >>> include/arith_exc_pkg.sv
// Types shared by the arithmetic exception register group
`default_nettype none

package arith_exc_pkg;
  // Condition vector order: [5] zero divide, [4] inexact, [3] underflow,
  // [2] overflow, [1] reserved operand, [0] invalid operation
  typedef logic [5:0] fp_cond_t;

  typedef enum logic [1:0] {
    RND_NEAREST = 2'b00,
    RND_MINUS = 2'b01,
    RND_PLUS = 2'b10,
    RND_ZERO = 2'b11
  } round_mode_t;

  // Whole register state of the group
  typedef struct packed {
    logic [1:0] bp;
    logic [4:0] fc;
    logic [7:0] cr;
    logic [8:0] fenv;
    logic [1:0] ienv;
    fp_cond_t trap_flags;
    fp_cond_t sticky;
    logic [7:0] opcode;
    logic [31:0] rdata;
    logic fp_trap;
    logic oor_trap;
  } state_t;
endpackage

`default_nettype wire

// >>> include/exc_eval_if.sv
// Signals between the register group and its two trap evaluators
`default_nettype none

interface exc_eval_if;
  import arith_exc_pkg::*;
  logic fp_valid;
  fp_cond_t fp_cond;
  fp_cond_t fp_mask;
  logic fp_trap;
  fp_cond_t trap_flags_nxt;
  fp_cond_t sticky_set;
  logic int_valid;
  logic int_is_div;
  logic int_div_zero;
  logic int_overflow;
  logic div_mask;
  logic mul_mask;
  logic oor_trap;

  modport core (
    output fp_valid, fp_cond, fp_mask, int_valid, int_is_div, int_div_zero,
    output int_overflow, div_mask, mul_mask,
    input fp_trap, trap_flags_nxt, sticky_set, oor_trap
  );
  modport fp_eval (
    input fp_valid, fp_cond, fp_mask,
    output fp_trap, trap_flags_nxt, sticky_set
  );
  modport int_eval (
    input int_valid, int_is_div, int_div_zero, int_overflow, div_mask, mul_mask,
    output oor_trap
  );
endinterface

`default_nettype wire

// >>> verilog/fp_trap_eval.sv
// Floating-point trap decision, trap flag and sticky flag evaluation
`default_nettype none

module fp_trap_eval #(
  parameter int COND_W = 6
) (
  exc_eval_if.fp_eval ev
);
  import arith_exc_pkg::*;

  // ----------------------------------------------------------------
  // Trap decision
  // ----------------------------------------------------------------
  // Trap only when some detected condition is unmasked
  assign ev.fp_trap = ev.fp_valid &
    (|(ev.fp_cond & ~ev.fp_mask));

  // ----------------------------------------------------------------
  // Per-condition flags
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < COND_W; i++) begin : g_cond
      // Trap flags report every applying cause, masked or not
      assign ev.trap_flags_nxt[i] = ev.fp_cond[i];
      // Sticky only for masked causes, even when another cause traps
      assign ev.sticky_set[i] = ev.fp_valid & ev.fp_cond[i] & ev.fp_mask[i];
    end
  endgenerate
endmodule

`default_nettype wire

// >>> verilog/int_trap_eval.sv
// Integer multiply and divide out-of-range trap decision
`default_nettype none

module int_trap_eval (
  exc_eval_if.int_eval ev
);
  import arith_exc_pkg::*;

  logic ovf_trap;
  logic zero_trap;

  // ----------------------------------------------------------------
  // Out-of-range decision
  // ----------------------------------------------------------------
  // Divide by zero ignores the divide overflow mask
  assign zero_trap = ev.int_is_div & ev.int_div_zero;
  // Overflow mask depends on the instruction type
  assign ovf_trap = ev.int_overflow &
    (ev.int_is_div ? ~ev.div_mask : ~ev.mul_mask);
  assign ev.oor_trap = ev.int_valid & (zero_trap | ovf_trap);
endmodule

`default_nettype wire

// >>> verilog/arith_exc_regs.sv
// Arithmetic exception register group: aliases, environments, status, trap opcode
//
// Operation
// - Byte pointer alias writes only the pointer
// - Shift count alias writes only shift amount
// - Count alias reaches transfer count left only
// - Fast float bit selects relaxed float variants
// - Rounding field picks default rounding mode
// - Zero divide traps unless masked
// - Inexact result traps unless masked
// - Underflow traps unless masked
// - Overflow traps unless masked
// - Reserved operand traps unless masked
// - Invalid operation traps unless masked
// - Divide overflow traps unless masked
// - Integer divide by zero always traps
// - Multiply overflow traps unless masked
// - Trap sets applying flags, clears others
// - Non-trapping operations keep trap flags
// - Trap flag set even when own mask set
// - Sticky set only for masked detected cause
// - Sticky holds until software write clears
// - Masked sticky set even when trap taken
// - Trapping opcode captured entering write-back
// - Non-trapping instructions keep captured opcode
// - Pointer is two-bit byte selector field
// - Shift amount is five-bit funnel count
`include "arith_exc_defines.svh"
`default_nettype none

module arith_exc_regs #(
  parameter int OPCODE_W = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // Special register port
  input wire logic sr_wr_i,
  input wire logic [7:0] sr_addr_i,
  input wire logic [31:0] sr_wdata_i,
  output logic [31:0] sr_rdata_o,
  // Host register field updates from the rest of the core
  input wire logic bp_set_i,
  input wire logic [1:0] bp_val_i,
  input wire logic fc_set_i,
  input wire logic [4:0] fc_val_i,
  input wire logic cr_set_i,
  input wire logic [7:0] cr_val_i,
  // Floating-point operation results
  input wire logic fp_done_i,
  input wire arith_exc_pkg::fp_cond_t fp_cond_i,
  // Integer multiply and divide results
  input wire logic int_done_i,
  input wire logic int_is_div_i,
  input wire logic int_div_zero_i,
  input wire logic int_overflow_i,
  // Write-back stage
  input wire logic wb_enter_i,
  input wire logic wb_trap_i,
  input wire logic [OPCODE_W-1:0] wb_opcode_i,
  // Field and control outputs
  output logic [1:0] byte_lane_pointer_o,
  output logic [4:0] shift_amount_o,
  output logic [7:0] transfer_count_left_o,
  output logic fast_float_select_o,
  output arith_exc_pkg::round_mode_t rounding_select_o,
  output logic fp_trap_o,
  output logic oor_trap_o
);
  import arith_exc_pkg::*;

  state_t st_ff;
  state_t nxt_st;
  exc_eval_if ev ();

  // ----------------------------------------------------------------
  // Evaluators
  // ----------------------------------------------------------------
  // Mask bits come from the stored environments
  assign ev.fp_valid = fp_done_i;
  assign ev.fp_cond = fp_cond_i;
  assign ev.fp_mask = st_ff.fenv[`AEX_FENV_MASK_MSB:0];
  assign ev.int_valid = int_done_i;
  assign ev.int_is_div = int_is_div_i;
  assign ev.int_div_zero = int_div_zero_i;
  assign ev.int_overflow = int_overflow_i;
  assign ev.div_mask = st_ff.ienv[`AEX_IENV_DIV_BIT];
  assign ev.mul_mask = st_ff.ienv[`AEX_IENV_MUL_BIT];

  fp_trap_eval #(
    .COND_W(`AEX_COND_W)
  ) u_fp_eval (
    .ev(ev.fp_eval)
  );

  int_trap_eval u_int_eval (
    .ev(ev.int_eval)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unused bits read zero; unmapped numbers read zero
  function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `AEX_ADDR_BP_ALIAS: w[`AEX_BP_W-1:0] = s.bp;
      `AEX_ADDR_FC_ALIAS: w[`AEX_FC_W-1:0] = s.fc;
      `AEX_ADDR_CR_ALIAS: w[`AEX_CR_W-1:0] = s.cr;
      `AEX_ADDR_FENV: w[`AEX_FENV_W-1:0] = s.fenv;
      `AEX_ADDR_IENV: w[`AEX_IENV_W-1:0] = s.ienv;
      `AEX_ADDR_FSTAT: begin
        w[`AEX_FSTAT_TRAP_MSB:`AEX_FSTAT_TRAP_LSB] = s.trap_flags;
        w[`AEX_FSTAT_STICKY_MSB:0] = s.sticky;
      end
      `AEX_ADDR_OPCODE: w[`AEX_OPCODE_W-1:0] = s.opcode;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Priority: core events over software writes where both hit a field
  always_comb begin
    nxt_st = st_ff;

    // Alias writes touch only their own field; other host fields
    // live outside this group and are never driven here
    if (sr_wr_i && sr_addr_i == `AEX_ADDR_BP_ALIAS) begin
      nxt_st.bp = sr_wdata_i[`AEX_BP_W-1:0];
    end
    if (bp_set_i) begin
      nxt_st.bp = bp_val_i;
    end
    if (sr_wr_i && sr_addr_i == `AEX_ADDR_FC_ALIAS) begin
      nxt_st.fc = sr_wdata_i[`AEX_FC_W-1:0];
    end
    if (fc_set_i) begin
      nxt_st.fc = fc_val_i;
    end
    if (sr_wr_i && sr_addr_i == `AEX_ADDR_CR_ALIAS) begin
      nxt_st.cr = sr_wdata_i[`AEX_CR_W-1:0];
    end
    // Load/store multiple counting down wins over a software write
    if (cr_set_i) begin
      nxt_st.cr = cr_val_i;
    end

    // Environment registers; upper bits dropped on write
    if (sr_wr_i && sr_addr_i == `AEX_ADDR_FENV) begin
      nxt_st.fenv = sr_wdata_i[`AEX_FENV_W-1:0];
    end
    if (sr_wr_i && sr_addr_i == `AEX_ADDR_IENV) begin
      nxt_st.ienv = sr_wdata_i[`AEX_IENV_W-1:0];
    end

    // Status: software write first, then hardware events on top
    if (sr_wr_i && sr_addr_i == `AEX_ADDR_FSTAT) begin
      nxt_st.trap_flags = sr_wdata_i[`AEX_FSTAT_TRAP_MSB:`AEX_FSTAT_TRAP_LSB];
      nxt_st.sticky = sr_wdata_i[`AEX_FSTAT_STICKY_MSB:0];
    end
    // Whole flag set replaced on a trap, held otherwise
    if (ev.fp_trap) begin
      nxt_st.trap_flags = ev.trap_flags_nxt;
    end
    // OR in so a clear in the same cycle cannot lose a new event
    nxt_st.sticky = nxt_st.sticky | ev.sticky_set;

    // Opcode: software may write; a trapping instruction overrides
    if (sr_wr_i && sr_addr_i == `AEX_ADDR_OPCODE) begin
      nxt_st.opcode = sr_wdata_i[`AEX_OPCODE_W-1:0];
    end
    if (wb_enter_i && wb_trap_i) begin
      nxt_st.opcode = wb_opcode_i[`AEX_OPCODE_W-1:0];
    end

    // Trap strobes last one cycle
    nxt_st.fp_trap = ev.fp_trap;
    nxt_st.oor_trap = ev.oor_trap;

    // Read data one cycle after the address, from the stored state
    nxt_st.rdata = read_word(st_ff, sr_addr_i);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff.bp <= `AEX_RST_BP;
      st_ff.fc <= `AEX_RST_FC;
      st_ff.cr <= `AEX_RST_CR;
      st_ff.fenv <= `AEX_RST_FENV;
      st_ff.ienv <= `AEX_RST_IENV;
      st_ff.trap_flags <= `AEX_RST_COND;
      st_ff.sticky <= `AEX_RST_COND;
      st_ff.opcode <= `AEX_RST_OPCODE;
      st_ff.rdata <= `AEX_RST_RDATA;
      st_ff.fp_trap <= 1'b0;
      st_ff.oor_trap <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign sr_rdata_o = st_ff.rdata;
  assign byte_lane_pointer_o = st_ff.bp;
  assign shift_amount_o = st_ff.fc;
  assign transfer_count_left_o = st_ff.cr;
  // Float unit picks the relaxed datapath when this is high
  assign fast_float_select_o = st_ff.fenv[`AEX_FENV_FAST_BIT];
  // Encoding of the field equals the round_mode_t codes
  assign rounding_select_o =
    round_mode_t'(st_ff.fenv[`AEX_FENV_RND_MSB:`AEX_FENV_RND_LSB]);
  assign fp_trap_o = st_ff.fp_trap;
  assign oor_trap_o = st_ff.oor_trap;
endmodule

`default_nettype wire

// >>> test/arith_exc_checker.sv
// Port-level checker for the arithmetic exception register group
`default_nettype none

module arith_exc_checker
  import arith_exc_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sr_wr_i,
  input wire logic [7:0] sr_addr_i,
  input wire logic [31:0] sr_wdata_i,
  input wire logic [31:0] sr_rdata_o,
  input wire logic bp_set_i,
  input wire logic fc_set_i,
  input wire logic cr_set_i,
  input wire logic fp_done_i,
  input wire logic int_done_i,
  input wire logic int_is_div_i,
  input wire logic int_div_zero_i,
  input wire logic [1:0] byte_lane_pointer_o,
  input wire logic [4:0] shift_amount_o,
  input wire logic [7:0] transfer_count_left_o,
  input wire logic fast_float_select_o,
  input wire arith_exc_pkg::round_mode_t rounding_select_o,
  input wire logic fp_trap_o,
  input wire logic oor_trap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Properties, all in the core clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Core updates win the same cycle, so they are excluded
  sequence s_bp_wr;
    sr_wr_i && sr_addr_i == 8'h85 && !bp_set_i && !fc_set_i;
  endsequence
  sequence s_fenv_wr;
    sr_wr_i && sr_addr_i == 8'hA0;
  endsequence
  property p_bp;
    s_bp_wr |=> byte_lane_pointer_o == $past(sr_wdata_i[1:0]) && $stable(shift_amount_o);
  endproperty
  a_bp: assert property (p_bp) else $error("pointer alias write wrong");
  property p_fc;
    sr_wr_i && sr_addr_i == 8'h86 && !fc_set_i |=> shift_amount_o == $past(sr_wdata_i[4:0]);
  endproperty
  a_fc: assert property (p_fc) else $error("shift alias write wrong");
  property p_cr;
    sr_wr_i && sr_addr_i == 8'h87 && !cr_set_i |=>
      transfer_count_left_o == $past(sr_wdata_i[7:0]);
  endproperty
  a_cr: assert property (p_cr) else $error("count alias write wrong");
  property p_ff;
    s_fenv_wr |=> fast_float_select_o == $past(sr_wdata_i[8]);
  endproperty
  a_ff: assert property (p_ff) else $error("fast float select wrong");
  property p_rnd;
    s_fenv_wr |=> rounding_select_o == $past(sr_wdata_i[7:6]);
  endproperty
  a_rnd: assert property (p_rnd) else $error("rounding select wrong");
  property p_dzero;
    int_done_i && int_is_div_i && int_div_zero_i |=> oor_trap_o;
  endproperty
  a_dzero: assert property (p_dzero) else $error("divide by zero without trap");
  property p_fpidle;
    !fp_done_i |=> !fp_trap_o;
  endproperty
  a_fpidle: assert property (p_fpidle) else $error("float trap without operation");
  property p_unmap;
    !(sr_addr_i inside {8'h85, 8'h86, 8'h87, 8'hA0, 8'hA1, 8'hA2, 8'hA4}) |=> sr_rdata_o == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_zbits;
    sr_addr_i == 8'h85 ##1 sr_addr_i == 8'h86 |-> sr_rdata_o[31:2] == 0 ##1 sr_rdata_o[31:5] == 0;
  endproperty
  a_zbits: assert property (p_zbits) else $error("alias zero bits not zero");
endmodule

bind arith_exc_regs arith_exc_checker u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .sr_wr_i(sr_wr_i), .sr_addr_i(sr_addr_i),
  .sr_wdata_i(sr_wdata_i), .sr_rdata_o(sr_rdata_o), .bp_set_i(bp_set_i), .fc_set_i(fc_set_i),
  .cr_set_i(cr_set_i), .fp_done_i(fp_done_i), .int_done_i(int_done_i),
  .int_is_div_i(int_is_div_i), .int_div_zero_i(int_div_zero_i),
  .byte_lane_pointer_o(byte_lane_pointer_o), .shift_amount_o(shift_amount_o),
  .transfer_count_left_o(transfer_count_left_o), .fast_float_select_o(fast_float_select_o),
  .rounding_select_o(rounding_select_o), .fp_trap_o(fp_trap_o), .oor_trap_o(oor_trap_o)
);

`default_nettype wire

// >>> test/tb_arith_exception_env_status.sv
// Self-checking bench for the arithmetic exception register group
`default_nettype none

module tb_arith_exception_env_status;
  timeunit 1ns;
  timeprecision 1ns;
  import arith_exc_pkg::*;
  logic clk_i = 0, nrst_i = 0, sr_wr_i = 0, bp_set_i = 0, fc_set_i = 0, cr_set_i = 0;
  logic fp_done_i = 0, int_done_i = 0, int_is_div_i = 0, int_div_zero_i = 0;
  logic int_overflow_i = 0, wb_enter_i = 0, wb_trap_i = 0;
  logic fast_float_select_o, fp_trap_o, oor_trap_o;
  logic [7:0] sr_addr_i = 0, cr_val_i = 0, wb_opcode_i = 0, transfer_count_left_o;
  logic [31:0] sr_wdata_i = 0, sr_rdata_o;
  logic [1:0] bp_val_i = 0, byte_lane_pointer_o;
  logic [4:0] fc_val_i = 0, shift_amount_o;
  fp_cond_t fp_cond_i = 0;
  round_mode_t rounding_select_o;
  int num_errors = 0, tests_run = 0, cycles = 0;
  logic [7:0] addrs [8] = '{8'h85, 8'h86, 8'h87, 8'hA0, 8'hA1, 8'hA2, 8'hA4, 8'h84};
  // Integer cases: env, divide, zero divisor, overflow, expected trap
  logic [5:0] icase [7] = '{6'h0B, 6'h2A, 6'h3D, 6'h03, 6'h12, 6'h23, 6'h08};

  arith_exc_regs uut (
    .clk_i(clk_i), .nrst_i(nrst_i), .sr_wr_i(sr_wr_i), .sr_addr_i(sr_addr_i),
    .sr_wdata_i(sr_wdata_i), .sr_rdata_o(sr_rdata_o), .bp_set_i(bp_set_i), .bp_val_i(bp_val_i),
    .fc_set_i(fc_set_i), .fc_val_i(fc_val_i), .cr_set_i(cr_set_i), .cr_val_i(cr_val_i),
    .fp_done_i(fp_done_i), .fp_cond_i(fp_cond_i), .int_done_i(int_done_i),
    .int_is_div_i(int_is_div_i), .int_div_zero_i(int_div_zero_i),
    .int_overflow_i(int_overflow_i), .wb_enter_i(wb_enter_i), .wb_trap_i(wb_trap_i),
    .wb_opcode_i(wb_opcode_i), .byte_lane_pointer_o(byte_lane_pointer_o),
    .shift_amount_o(shift_amount_o), .transfer_count_left_o(transfer_count_left_o),
    .fast_float_select_o(fast_float_select_o), .rounding_select_o(rounding_select_o),
    .fp_trap_o(fp_trap_o), .oor_trap_o(oor_trap_o)
  );

  // ----------------------------------------------------------------
  // Clock, hang guard, shared tasks
  // ----------------------------------------------------------------
  always #25 clk_i = ~clk_i;
  // Whole run needs about 130 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Every task starts and ends just after a rising edge; strobe tasks
  // leave one idle edge so back-to-back calls never re-raise a strobe at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sr_wr_i = 1;
    sr_addr_i = a;
    sr_wdata_i = d;
    @(posedge clk_i);
    #1 sr_wr_i = 0;
    @(posedge clk_i);
    #1;
  endtask
  // Read data is registered: one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    sr_addr_i = a;
    @(posedge clk_i);
    #1 chk($sformatf("reg %h", a), sr_rdata_o, exp);
  endtask
  task automatic fp_ev(input fp_cond_t c, input logic t);
    fp_done_i = 1;
    fp_cond_i = c;
    @(posedge clk_i);
    #1 fp_done_i = 0;
    chk("fp_trap_o", fp_trap_o, t);
    @(posedge clk_i);
    #1;
  endtask
  task automatic int_ev(input logic [2:0] v, input logic t);
    int_done_i = 1;
    {int_is_div_i, int_div_zero_i, int_overflow_i} = v;
    @(posedge clk_i);
    #1 int_done_i = 0;
    chk("oor_trap_o", oor_trap_o, t);
    @(posedge clk_i);
    #1;
  endtask
  task automatic wb(input logic t, input logic [7:0] op);
    wb_enter_i = 1;
    wb_trap_i = t;
    wb_opcode_i = op;
    @(posedge clk_i);
    #1 wb_enter_i = 0;
    @(posedge clk_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    #1 nrst_i = 1;
    foreach (addrs[i]) rd(addrs[i], 0);
    wr(8'h85, 32'hFFFF_FFFF);
    rd(8'h85, 32'h3);
    chk("shift kept", shift_amount_o, 0);
    wr(8'h86, 32'hFFFF_FFFF);
    rd(8'h86, 32'h1F);
    chk("pointer kept", byte_lane_pointer_o, 2'h3);
    wr(8'h87, 32'hFFFF_FFFF);
    rd(8'h87, 32'hFF);
    chk("count", transfer_count_left_o, 8'hFF);
    // Host register updates from the core side
    {bp_set_i, fc_set_i, cr_set_i, bp_val_i, fc_val_i, cr_val_i} = {3'h7, 2'h1, 5'h02, 8'h03};
    @(posedge clk_i);
    #1 {bp_set_i, fc_set_i, cr_set_i} = 3'h0;
    rd(8'h85, 32'h1);
    chk("shift port", shift_amount_o, 5'h02);
    chk("count port", transfer_count_left_o, 8'h03);
    $display("test aliases done");
    wr(8'hA1, 32'hFFFF_FFFF);
    rd(8'hA1, 32'h3);
    for (int r = 0; r < 4; r++) begin
      wr(8'hA0, 32'h100 | (r << 6));
      chk("rounding", rounding_select_o, r);
      chk("fast", fast_float_select_o, 1'b1);
    end
    wr(8'hA0, 32'hFFFF_FFFF);
    rd(8'hA0, 32'h1FF);
    $display("test environment done");
    // Unmasked causes each trap alone
    wr(8'hA0, 32'h0);
    for (int i = 0; i < 6; i++) begin
      fp_ev(6'h01 << i, 1'b1);
      rd(8'hA2, 32'h100 << i);
    end
    // Masked causes never trap, they only accumulate sticky bits
    wr(8'hA0, 32'h3F);
    for (int i = 0; i < 6; i++) fp_ev(6'h01 << i, 1'b0);
    rd(8'hA2, 32'h203F);
    wr(8'hA2, 32'h0);
    wr(8'hA0, 32'h10);
    fp_ev(6'h30, 1'b1);
    rd(8'hA2, 32'h3010);
    fp_ev(6'h01, 1'b1);
    rd(8'hA2, 32'h0110);
    wr(8'hA2, 32'h0);
    rd(8'hA2, 32'h0);
    $display("test float status done");
    foreach (icase[i]) begin
      wr(8'hA1, icase[i][5:4]);
      int_ev(icase[i][3:1], icase[i][0]);
    end
    $display("test integer done");
    wb(1'b1, 8'hA5);
    rd(8'hA4, 32'hA5);
    wb(1'b0, 8'h3C);
    rd(8'hA4, 32'hA5);
    $display("test opcode done");
    give_verdict();
  end
endmodule

`default_nettype wire
